/* File: rtl/dgsc_params.svh */
`ifndef DGSC_PARAMS_SVH
`define DGSC_PARAMS_SVH
// Register byte offsets
`define DGSC_OFF_CONTROL   8'h00
`define DGSC_OFF_STATUS    8'h04
`define DGSC_OFF_ADDRESS   8'h08
`define DGSC_OFF_CRC_CTRL  8'h0C
// Global control fields
`define DGSC_CTL_ON_BIT    15
`define DGSC_CTL_SUSP_BIT  12
`define DGSC_CTL_BUSY_BIT  11
// Status fields
`define DGSC_STA_DIR_BIT   3
`define DGSC_STA_CH_MSB    2
// CRC control fields
`define DGSC_CRC_CRC_BYTE_ORDER_SEL_MSB  29
`define DGSC_CRC_CRC_BYTE_ORDER_SEL_LSB  28
`define DGSC_CRC_WBO_BIT   27
`define DGSC_CRC_CRC_BIT_REFLECT_BIT  24
`define DGSC_CRC_POLYNOMIAL_LENGTH_MSB  12
`define DGSC_CRC_POLYNOMIAL_LENGTH_LSB  8
`define DGSC_CRC_EN_BIT    7
`define DGSC_CRC_APP_BIT   6
`define DGSC_CRC_TYP_BIT   5
`define DGSC_CRC_CH_MSB    2
// Writable masks and reset values
`define DGSC_CTL_WMASK     32'h0000_9000
`define DGSC_CRC_WMASK     32'h3900_1FE7
`define DGSC_RST_ZERO      32'h0000_0000
`endif

/* File: rtl/dgsc_pkg.sv */
package dgsc_pkg;
  typedef enum logic [1:0] {
    DGSC_CRC_BYTE_ORDER_SEL_NONE  = 2'b00,
    DGSC_CRC_BYTE_ORDER_SEL_WORD  = 2'b01,
    DGSC_CRC_BYTE_ORDER_SEL_HALF  = 2'b10,
    DGSC_CRC_BYTE_ORDER_SEL_HSWAP = 2'b11
  } dgsc_crc_byte_order_sel_e;
  typedef enum logic [1:0] {
    DGSC_RD_IDLE = 2'b00,
    DGSC_RD_RESP = 2'b01
  } dgsc_rd_state_e;
  typedef logic [31:0] dgsc_word_t;
endpackage : dgsc_pkg

/* File: rtl/dgsc_top.sv */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`include "dgsc_params.svh"
module dgsc_top
  import dgsc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        xfer_req_in,
  input  wire logic        xfer_active_in,
  input  wire logic        acc_valid_in,
  input  wire logic        acc_read_in,
  input  wire logic [2:0]  acc_channel_in,
  input  wire logic [31:0] acc_address_in,
  input  wire logic [31:0] src_data_in,
  output logic             xfer_grant_out,
  output logic             module_on_out,
  output logic [31:0]      dest_data_out,
  output logic [31:0]      crc_data_out,
  output logic             crc_route_out,
  output logic             crc_ip_mode_out,
  output logic             crc_reflect_out,
  output logic             crc_append_out,
  output logic [4:0]       crc_poly_len_out,
  output logic [2:0]       crc_channel_out
);

  logic [31:0]    dma_global_control;
  logic [31:0]    dma_crc_control;
  logic           last_access_direction;
  logic [2:0]     last_active_channel;
  logic [31:0]    last_access_address;
  logic           module_active_flag;
  logic [7:0]     aw_addr;
  logic           aw_held;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic           w_held;
  logic           wr_fire;
  logic           wr_hit;
  logic [31:0]    next_control;
  logic [31:0]    next_crc;
  logic [31:0]    rd_word;
  logic           rd_hit;
  dgsc_rd_state_e rd_state;
  dgsc_crc_byte_order_sel_e     crc_byte_order_sel_sel;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb,
                                              input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge_bytes = (old_v & ~m) | (new_v & m);
  endfunction : merge_bytes

  function automatic logic [31:0] reorder(input logic [31:0] d, input dgsc_crc_byte_order_sel_e sel);
    case (sel)
      DGSC_CRC_BYTE_ORDER_SEL_HSWAP: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
      DGSC_CRC_BYTE_ORDER_SEL_WORD:  reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
      DGSC_CRC_BYTE_ORDER_SEL_HALF:  reorder = {d[15:0], d[31:16]};
      default:         reorder = d;
    endcase
  endfunction : reorder

  // Write channel: address and data accepted in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held           <= 1'b0;
      aw_addr           <= 8'h00;
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !s_axi_awready_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held           <= 1'b1;
        aw_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      w_held           <= 1'b0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_held && !s_axi_wready_out;
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held           <= 1'b1;
        w_data           <= s_axi_wdata_in;
        w_strb           <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  assign wr_hit = (aw_addr == `DGSC_OFF_CONTROL) || (aw_addr == `DGSC_OFF_STATUS)
               || (aw_addr == `DGSC_OFF_ADDRESS) || (aw_addr == `DGSC_OFF_CRC_CTRL);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Only the writable masks reach the registers, so reserved bits stay zero
  always_comb begin
    next_control = merge_bytes(dma_global_control, w_data, w_strb, `DGSC_CTL_WMASK);
    next_crc     = merge_bytes(dma_crc_control, w_data, w_strb, `DGSC_CRC_WMASK);
    if (next_crc[`DGSC_CRC_WBO_BIT]) begin
      next_crc[`DGSC_CRC_APP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dma_global_control <= `DGSC_RST_ZERO;
    end else if (wr_fire && aw_addr == `DGSC_OFF_CONTROL) begin
      dma_global_control <= next_control;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dma_crc_control <= `DGSC_RST_ZERO;
    end else if (wr_fire && aw_addr == `DGSC_OFF_CRC_CTRL) begin
      dma_crc_control <= next_crc;
    end
  end

  // Busy stays high until an in-flight transfer drains after disable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      module_active_flag <= 1'b0;
    end else begin
      module_active_flag <= dma_global_control[`DGSC_CTL_ON_BIT] || xfer_active_in;
    end
  end

  // The three snapshots share one enable so they always describe one access
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      last_access_direction <= 1'b0;
      last_active_channel   <= 3'h0;
      last_access_address   <= 32'h0000_0000;
    end else if (acc_valid_in) begin
      last_access_direction <= acc_read_in;
      last_active_channel   <= acc_channel_in;
      last_access_address   <= acc_address_in;
    end
  end

  // Read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_in)
      `DGSC_OFF_CONTROL: begin
        rd_word = dma_global_control;
        rd_word[`DGSC_CTL_BUSY_BIT] = module_active_flag;
      end
      `DGSC_OFF_STATUS: begin
        rd_word[`DGSC_STA_DIR_BIT] = last_access_direction;
        rd_word[`DGSC_STA_CH_MSB:0] = last_active_channel;
      end
      `DGSC_OFF_ADDRESS:  rd_word = last_access_address;
      `DGSC_OFF_CRC_CTRL: rd_word = dma_crc_control;
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_state          <= DGSC_RD_IDLE;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= 2'b00;
    end else begin
      case (rd_state)
        DGSC_RD_IDLE: begin
          s_axi_arready_out <= 1'b1;
          if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            s_axi_rresp_out   <= rd_hit ? 2'b00 : 2'b10;
            rd_state          <= DGSC_RD_RESP;
          end
        end
        DGSC_RD_RESP: begin
          if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            rd_state         <= DGSC_RD_IDLE;
          end
        end
        default: rd_state <= DGSC_RD_IDLE;
      endcase
    end
  end

  // Datapath toward the transfer engine and CRC unit
  assign crc_byte_order_sel_sel = dgsc_crc_byte_order_sel_e'(dma_crc_control[`DGSC_CRC_CRC_BYTE_ORDER_SEL_MSB:`DGSC_CRC_CRC_BYTE_ORDER_SEL_LSB]);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_grant_out <= 1'b0;
      module_on_out  <= 1'b0;
    end else begin
      module_on_out  <= dma_global_control[`DGSC_CTL_ON_BIT];
      xfer_grant_out <= xfer_req_in && dma_global_control[`DGSC_CTL_ON_BIT]
                        && !dma_global_control[`DGSC_CTL_SUSP_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dest_data_out <= 32'h0000_0000;
      crc_data_out  <= 32'h0000_0000;
    end else begin
      crc_data_out  <= reorder(src_data_in, crc_byte_order_sel_sel);
      dest_data_out <= dma_crc_control[`DGSC_CRC_WBO_BIT] ?
                       reorder(src_data_in, crc_byte_order_sel_sel) : src_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      crc_route_out    <= 1'b0;
      crc_ip_mode_out  <= 1'b0;
      crc_reflect_out  <= 1'b0;
      crc_append_out   <= 1'b0;
      crc_poly_len_out <= 5'h00;
      crc_channel_out  <= 3'h0;
    end else begin
      crc_route_out    <= dma_crc_control[`DGSC_CRC_EN_BIT];
      crc_ip_mode_out  <= dma_crc_control[`DGSC_CRC_TYP_BIT];
      crc_reflect_out  <= dma_crc_control[`DGSC_CRC_CRC_BIT_REFLECT_BIT];
      crc_append_out   <= dma_crc_control[`DGSC_CRC_APP_BIT];
      crc_poly_len_out <= dma_crc_control[`DGSC_CRC_POLYNOMIAL_LENGTH_MSB:`DGSC_CRC_POLYNOMIAL_LENGTH_LSB];
      crc_channel_out  <= dma_crc_control[`DGSC_CRC_CH_MSB:0];
    end
  end

  // Assertions
  grant_needs_on_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    xfer_grant_out |-> $past(dma_global_control[`DGSC_CTL_ON_BIT]))
    else $error("grant while module off");
  suspend_blocks_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dma_global_control[`DGSC_CTL_SUSP_BIT] |=> !xfer_grant_out)
    else $error("grant while suspended");
  busy_tracks_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (dma_global_control[`DGSC_CTL_ON_BIT] || xfer_active_in) |=> module_active_flag)
    else $error("busy flag low while active");
  idle_not_busy_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!dma_global_control[`DGSC_CTL_ON_BIT] && !xfer_active_in) |=> !module_active_flag)
    else $error("busy flag high while idle");
  snapshot_dir_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    acc_valid_in |=> last_access_direction == $past(acc_read_in))
    else $error("direction not captured");
  snapshot_ch_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    acc_valid_in |=> last_active_channel == $past(acc_channel_in))
    else $error("channel not captured");
  snapshot_addr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    acc_valid_in |=> last_access_address == $past(acc_address_in))
    else $error("address not captured");
  reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ((dma_crc_control & ~`DGSC_CRC_WMASK) == 32'h0000_0000)
    && ((dma_global_control & ~`DGSC_CTL_WMASK) == 32'h0000_0000))
    else $error("reserved bit set");
  hswap_order_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    crc_byte_order_sel_sel == DGSC_CRC_BYTE_ORDER_SEL_HSWAP |=> crc_data_out[7:0] == $past(src_data_in[15:8]))
    else $error("half-word byte swap wrong");
  word_reverse_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    crc_byte_order_sel_sel == DGSC_CRC_BYTE_ORDER_SEL_WORD |=> crc_data_out[31:24] == $past(src_data_in[7:0]))
    else $error("word byte reversal wrong");
  half_swap_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    crc_byte_order_sel_sel == DGSC_CRC_BYTE_ORDER_SEL_HALF |=> crc_data_out[15:0] == $past(src_data_in[31:16]))
    else $error("half-word exchange wrong");
  dest_plain_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !dma_crc_control[`DGSC_CRC_WBO_BIT] |=> dest_data_out == $past(src_data_in))
    else $error("destination data altered");
  dest_reorder_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dma_crc_control[`DGSC_CRC_WBO_BIT] |=> dest_data_out == crc_data_out)
    else $error("destination not reordered");
  reflect_out_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 crc_reflect_out == $past(dma_crc_control[`DGSC_CRC_CRC_BIT_REFLECT_BIT]))
    else $error("bit order not passed on");
  ip_mode_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 crc_ip_mode_out == $past(dma_crc_control[`DGSC_CRC_TYP_BIT]))
    else $error("checksum type not passed on");
  route_out_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 crc_route_out == $past(dma_crc_control[`DGSC_CRC_EN_BIT]))
    else $error("crc routing not passed on");
  no_append_wbo_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(dma_crc_control[`DGSC_CRC_WBO_BIT] && dma_crc_control[`DGSC_CRC_APP_BIT]))
    else $error("append set with write reorder");

endmodule : dgsc_top

/* File: tb/dgsc_engine_model.sv */
module dgsc_engine_model
  import dgsc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic        rd_in,
  input  wire logic [2:0]  ch_in,
  input  wire logic [31:0] addr_in,
  input  wire dgsc_word_t  data_in,
  input  wire logic        grant_in,
  output logic             xfer_req_out,
  output logic             xfer_active_out,
  output logic             acc_valid_out,
  output logic             acc_read_out,
  output logic [2:0]       acc_channel_out,
  output logic [31:0]      acc_address_out,
  output dgsc_word_t       src_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] held;
  assign xfer_active_out = xfer_req_out | acc_valid_out;
  // A request waits for grant; a released bus inverts itself every edge, so it shows the last access again every other cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_req_out <= 1'b0;
      acc_valid_out <= 1'b0;
      held <= '0;
      {acc_read_out, acc_channel_out, acc_address_out} <= '0;
    end else begin
      acc_valid_out <= 1'b0;
      {acc_read_out, acc_channel_out, acc_address_out} <=
        ~{acc_read_out, acc_channel_out, acc_address_out};
      if (go_in) begin
        xfer_req_out <= 1'b1;
        held <= {rd_in, ch_in, addr_in};
      end else if (xfer_req_out && grant_in) begin
        xfer_req_out <= 1'b0;
        acc_valid_out <= 1'b1;
        {acc_read_out, acc_channel_out, acc_address_out} <= held;
      end
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      src_data_out <= '0;
    end else begin
      src_data_out <= data_in;
    end
  end
endmodule : dgsc_engine_model

/* File: tb/test_dgsc_top.sv */
`include "dgsc_params.svh"
module test_dgsc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, xfer_req_in;
  logic        xfer_active_in, acc_valid_in, acc_read_in, xfer_grant_out, module_on_out;
  logic        crc_route_out, crc_ip_mode_out, crc_reflect_out, crc_append_out, go, go_rd;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, last_resp;
  logic [2:0]  acc_channel_in, crc_channel_out, go_ch, k;
  logic [4:0]  crc_poly_len_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, acc_address_in, src_data_in, dest_data_out;
  logic [31:0] crc_data_out, go_addr, src_w, rd_d, v, e;
  int          n_fail, compares;

  dgsc_top dut_u (.clk_sys_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .xfer_req_in, .xfer_active_in,
    .acc_valid_in, .acc_read_in, .acc_channel_in, .acc_address_in, .src_data_in,
    .xfer_grant_out, .module_on_out, .dest_data_out, .crc_data_out, .crc_route_out,
    .crc_ip_mode_out, .crc_reflect_out, .crc_append_out, .crc_poly_len_out, .crc_channel_out);

  dgsc_engine_model em_u (.clk_sys_in, .rst_in, .go_in(go), .rd_in(go_rd), .ch_in(go_ch),
    .addr_in(go_addr), .data_in(src_w), .grant_in(xfer_grant_out), .xfer_req_out(xfer_req_in),
    .xfer_active_out(xfer_active_in), .acc_valid_out(acc_valid_in), .acc_read_out(acc_read_in),
    .acc_channel_out(acc_channel_in), .acc_address_out(acc_address_in),
    .src_data_out(src_data_in));

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Address and data are offered together and each is dropped as soon as it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_in);
      if (!aw_done && s_axi_awready_out === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w_done && s_axi_wready_out === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge clk_sys_in); while (s_axi_bvalid_out !== 1'b1);
    last_resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'b1);
    rd_d = s_axi_rdata_out;
    last_resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_d, exp);
  endtask : rd_chk

  // One access request from the engine side; it waits for grant on its own
  task automatic xfer(input logic r, input logic [2:0] c, input logic [31:0] a);
    @(posedge clk_sys_in);
    go <= 1'b1;
    go_rd <= r;
    go_ch <= c;
    go_addr <= a;
    @(posedge clk_sys_in);
    go <= 1'b0;
    tick(6);
  endtask : xfer

  function automatic logic [31:0] reorder(input logic [1:0] b, input logic [31:0] s);
    case (b)
      2'b01:   return {s[7:0], s[15:8], s[23:16], s[31:24]};
      2'b10:   return {s[15:0], s[31:16]};
      2'b11:   return {s[23:16], s[31:24], s[7:0], s[15:8]};
      default: return s;
    endcase
  endfunction : reorder

  task automatic give_verdict();
    $display("TB: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    {clk_sys_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, go, go_rd, go_ch, go_addr, s_axi_awaddr_in, s_axi_araddr_in} = '0;
    {s_axi_wstrb_in, s_axi_wdata_in} = '0;
    src_w = 32'h1122_3344;
    rst_in = 1'b1;
    tick(6);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(8'(i * 4), 32'h0);
    rd(8'h10);
    check(last_resp, 2'b10);
    check(rd_d, 32'h0);
    wr(`DGSC_OFF_CONTROL, 32'hFFFF_FFFF, 4'h1);
    rd_chk(`DGSC_OFF_CONTROL, 32'h0);
    wr(`DGSC_OFF_CONTROL, 32'hFFFF_FFFF, 4'hF);
    rd_chk(`DGSC_OFF_CONTROL, 32'h0000_9800);
    check(module_on_out, 1'b1);
    xfer(1'b1, 3'h5, 32'h1234_5678);
    rd_chk(`DGSC_OFF_STATUS, 32'h0);
    check(xfer_grant_out, 1'b0);
    wr(`DGSC_OFF_CONTROL, 32'h0000_8000, 4'hF);
    tick(4);
    rd_chk(`DGSC_OFF_STATUS, 32'h0000_000D);
    rd_chk(`DGSC_OFF_ADDRESS, 32'h1234_5678);
    xfer(1'b0, 3'h2, 32'hCAFE_0010);
    rd_chk(`DGSC_OFF_STATUS, 32'h0000_0002);
    rd_chk(`DGSC_OFF_ADDRESS, 32'hCAFE_0010);
    wr(`DGSC_OFF_CONTROL, 32'h0, 4'hF);
    tick(2);
    rd_chk(`DGSC_OFF_CONTROL, 32'h0);
    check(module_on_out, 1'b0);
    xfer(1'b1, 3'h7, 32'h0000_00A5);
    rd_chk(`DGSC_OFF_CONTROL, 32'h0000_0800);
    rd_chk(`DGSC_OFF_STATUS, 32'h0000_0002);
    wr(`DGSC_OFF_CONTROL, 32'h0000_8000, 4'hF);
    tick(4);
    rd_chk(`DGSC_OFF_STATUS, 32'h0000_000F);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF);
    check(last_resp, 2'b10);
    wr(`DGSC_OFF_CRC_CTRL, 32'hFFFF_FFFF, 4'hF);
    rd_chk(`DGSC_OFF_CRC_CTRL, 32'h3900_1FA7);
    check({crc_route_out, crc_ip_mode_out, crc_reflect_out, crc_append_out,
           crc_poly_len_out, crc_channel_out}, 32'h0000_0EFF);
    wr(`DGSC_OFF_CRC_CTRL, 32'h0000_0040, 4'hF);
    // The copy lags the register by one edge, so wait for it to settle
    tick(1);
    check(crc_append_out, 1'b1);
    wr(`DGSC_OFF_CRC_CTRL, 32'h0800_0040, 4'hF);
    rd_chk(`DGSC_OFF_CRC_CTRL, 32'h0800_0000);
    // Every byte order, both destination modes, both bit orders under both types
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      v = {2'b00, k[1:0], k[2], 2'b00, ~k[0], 18'h0, k[1], 5'h0};
      wr(`DGSC_OFF_CRC_CTRL, v, 4'hF);
      tick(3);
      e = reorder(k[1:0], 32'h1122_3344);
      check(crc_data_out, e);
      check(dest_data_out, k[2] ? e : 32'h1122_3344);
      check(crc_reflect_out, !k[0]);
      check(crc_ip_mode_out, k[1]);
      check(crc_route_out, 1'b0);
    end
    give_verdict();
  end
endmodule : test_dgsc_top
